// ==== hsdt_decode.v ====
// Halfword and signed-data load/store decode and execute unit.
// Assumes the register file presents base, index and store values with the
// instruction, and a memory port that acknowledges with mem_ack.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "hsdt_regs.vh"
module hsdt_decode
(
   input  wire        clk_sys,
   input  wire        rst,
   input  wire [31:0] instr,
   input  wire        instr_valid,
   output reg         instr_ready_ff,
   input  wire [3:0]  flags_nzcv,
   input  wire [31:0] base_value,
   input  wire [31:0] index_value,
   input  wire [31:0] store_value,
   input  wire        endian_select_input,
   output reg         mem_req_ff,
   output reg  [31:0] mem_addr_ff,
   output reg         mem_write_ff,
   output reg         mem_half_ff,
   output reg  [31:0] mem_wdata_ff,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata,
   output reg         load_we_ff,
   output reg  [3:0]  load_reg_ff,
   output reg  [31:0] load_data_ff,
   output reg         base_we_ff,
   output reg  [3:0]  base_reg_ff,
   output reg  [31:0] base_data_ff,
   output reg         done_ff,
   output reg         swap_route_ff,
   output reg         not_decoded_ff,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout_ff,
   output reg         hresp_ff,
   output reg  [31:0] hrdata_ff
);
   localparam ST_IDLE = 2'h0;
   localparam ST_MEM  = 2'h1;
   localparam ST_WB   = 2'h2;

   reg  [1:0]  state_ff;
   reg  [1:0]  nxt_state;
   reg         enable_ff;
   reg         skip_ff;
   reg  [31:0] count_ff;
   reg  [31:0] last_addr_ff;
   reg         is_load_ff;
   reg         is_signed_ff;
   reg         is_half_ff;
   reg         do_wb_ff;
   reg         big_ff;
   reg  [3:0]  rd_ff;
   reg  [3:0]  rn_ff;
   reg  [31:0] modified_ff;
   reg  [31:0] rdata_ff;
   reg         wr_pend_ff;
   reg  [7:0]  wr_addr_ff;

   wire [7:0]  imm_off;
   wire [31:0] offset;
   wire [31:0] modified;
   wire        form_ok;
   wire        sh_zero;
   wire        cond_pass;
   wire        take;
   wire [31:0] aligned;

   // Condition check on the flags sampled with the instruction. The never
   // code falls to the default branch, so it can never start a transfer.
   function cond_eval;
      input [3:0] cond;
      input [3:0] f;
      reg n, z, c, v;
      begin
         n = f[3];
         z = f[2];
         c = f[1];
         v = f[0];
         case (cond)
            4'h0: cond_eval = z;
            4'h1: cond_eval = !z;
            4'h2: cond_eval = c;
            4'h3: cond_eval = !c;
            4'h4: cond_eval = n;
            4'h5: cond_eval = !n;
            4'h6: cond_eval = v;
            4'h7: cond_eval = !v;
            4'h8: cond_eval = c && !z;
            4'h9: cond_eval = !c || z;
            4'ha: cond_eval = n == v;
            4'hb: cond_eval = n != v;
            4'hc: cond_eval = !z && (n == v);
            4'hd: cond_eval = z || (n != v);
            4'he: cond_eval = 1'b1;
            default: cond_eval = 1'b0;
         endcase
      end
   endfunction

   // Immediate offsets are unsigned; the register form applies the index
   // value as it stands, since this encoding space has no shifter.
   assign imm_off  = {instr[11:8], instr[3:0]};
   assign offset   = instr[`HSDT_BIT_IMM] ? {24'h000000, imm_off}
                                          : index_value;
   assign modified = instr[`HSDT_BIT_U] ? base_value + offset
                                        : base_value - offset;
   // Bits 11..8 must be zero only in the register form.
   assign form_ok  = (instr[27:25] == 3'h0) && instr[7] && instr[4] &&
                     (instr[`HSDT_BIT_IMM] || instr[11:8] == 4'h0);
   assign sh_zero  = !instr[`HSDT_BIT_S] && !instr[`HSDT_BIT_H];
   assign cond_pass = cond_eval(instr[31:28], flags_nzcv);
   assign take     = instr_valid && instr_ready_ff && enable_ff;

   // The lane pick works on registered copies, keeping it off the bus path.
   hsdt_load_align u_align
   (
      .rdata      (rdata_ff),
      .addr_lo    (mem_addr_ff[1:0]),
      .big_endian (big_ff),
      .signed_op  (is_signed_ff),
      .half_op    (is_half_ff),
      .result     (aligned)
   );

   // The unit stays busy from the take until the write-back pulses, so
   // only one instruction is ever in flight.
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (take && form_ok && !sh_zero && cond_pass)
               nxt_state = ST_MEM;
         ST_MEM:
            if (mem_ack)
               nxt_state = ST_WB;
         ST_WB:
            nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_ff       <= ST_IDLE;
         instr_ready_ff <= 1'b0;
         mem_req_ff     <= 1'b0;
         mem_addr_ff    <= 32'h00000000;
         mem_write_ff   <= 1'b0;
         mem_half_ff    <= 1'b0;
         mem_wdata_ff   <= 32'h00000000;
         load_we_ff     <= 1'b0;
         load_reg_ff    <= 4'h0;
         load_data_ff   <= 32'h00000000;
         base_we_ff     <= 1'b0;
         base_reg_ff    <= 4'h0;
         base_data_ff   <= 32'h00000000;
         done_ff        <= 1'b0;
         swap_route_ff  <= 1'b0;
         not_decoded_ff <= 1'b0;
         skip_ff        <= 1'b0;
         count_ff       <= 32'h00000000;
         is_load_ff     <= 1'b0;
         is_signed_ff   <= 1'b0;
         is_half_ff     <= 1'b0;
         do_wb_ff       <= 1'b0;
         big_ff         <= 1'b0;
         rd_ff          <= 4'h0;
         rn_ff          <= 4'h0;
         modified_ff    <= 32'h00000000;
         rdata_ff       <= 32'h00000000;
      end
      else
      begin
         state_ff       <= nxt_state;
         instr_ready_ff <= (nxt_state == ST_IDLE);
         load_we_ff     <= 1'b0;
         base_we_ff     <= 1'b0;
         done_ff        <= 1'b0;
         swap_route_ff  <= 1'b0;
         not_decoded_ff <= 1'b0;
         case (state_ff)
            ST_IDLE:
               if (take)
               begin
                  if (!form_ok)
                     not_decoded_ff <= 1'b1;
                  else if (sh_zero)
                     swap_route_ff <= 1'b1;
                  else if (!cond_pass)
                  begin
                     skip_ff <= 1'b1;
                     done_ff <= 1'b1;
                  end
                  else
                  begin
                     skip_ff      <= 1'b0;
                     mem_req_ff   <= 1'b1;
                     mem_addr_ff  <= instr[`HSDT_BIT_P] ? modified
                                                        : base_value;
                     mem_write_ff <= !instr[`HSDT_BIT_L];
                     mem_half_ff  <= instr[`HSDT_BIT_H];
                     mem_wdata_ff <= {store_value[15:0],
                                      store_value[15:0]};
                     is_load_ff   <= instr[`HSDT_BIT_L];
                     is_signed_ff <= instr[`HSDT_BIT_S];
                     is_half_ff   <= instr[`HSDT_BIT_H];
                     // Post-indexing always writes back; pre-indexing only when W is set.
                     do_wb_ff     <= !instr[`HSDT_BIT_P] ||
                                     instr[`HSDT_BIT_W];
                     big_ff       <= endian_select_input;
                     rd_ff        <= instr[15:12];
                     rn_ff        <= instr[19:16];
                     modified_ff  <= modified;
                  end
               end
            ST_MEM:
               // Read data is caught here because the bus is only valid
               // with the ack; the lane pick follows one cycle later.
               if (mem_ack)
               begin
                  mem_req_ff <= 1'b0;
                  rdata_ff   <= mem_rdata;
               end
            ST_WB:
            begin
               done_ff      <= 1'b1;
               // The count wraps silently; software treats it as a tally.
               count_ff     <= count_ff + 32'h00000001;
               load_we_ff   <= is_load_ff;
               load_reg_ff  <= rd_ff;
               load_data_ff <= aligned;
               // A load into the base register keeps the loaded value.
               base_we_ff   <= do_wb_ff &&
                               !(is_load_ff && rd_ff == rn_ff);
               base_reg_ff  <= rn_ff;
               base_data_ff <= modified_ff;
            end
            default:
               mem_req_ff <= 1'b0;
         endcase
      end
   end

   // AHB-Lite slave with zero wait states; read data is prepared in the
   // address phase so that it can come straight from a flip-flop.
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
         hrdata_ff    <= 32'h00000000;
         wr_pend_ff   <= 1'b0;
         wr_addr_ff   <= 8'h00;
         enable_ff    <= 1'b1;
         last_addr_ff <= 32'h00000000;
      end
      else
      begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
         if (state_ff == ST_WB)
            last_addr_ff <= mem_addr_ff;
         // A write lands only in the cycle in which its data phase ends.
         if (hready && wr_pend_ff &&
             wr_addr_ff == `HSDT_CTRL_ADDR)
            enable_ff <= hwdata[`HSDT_CTRL_EN_BIT];
         if (hready)
         begin
            wr_pend_ff <= hsel && htrans == `HSDT_HTRANS_NONSEQ && hwrite;
            wr_addr_ff <= haddr[7:0];
            hrdata_ff  <= 32'h00000000;
            if (hsel && htrans == `HSDT_HTRANS_NONSEQ && !hwrite)
               case (haddr[7:0])
                  `HSDT_CTRL_ADDR:
                     hrdata_ff <= {31'h00000000, enable_ff};
                  `HSDT_STATUS_ADDR:
                     hrdata_ff <= {29'h00000000, swap_route_ff, skip_ff,
                                   state_ff != ST_IDLE};
                  `HSDT_COUNT_ADDR:
                     hrdata_ff <= count_ff;
                  `HSDT_LASTADDR_ADDR:
                     hrdata_ff <= last_addr_ff;
                  // Unmapped offsets read as zero; writes to them are lost.
                  default:
                     hrdata_ff <= 32'h00000000;
               endcase
         end
      end
   end
endmodule

// ==== hsdt_regs.vh ====
// Constants for the halfword and signed transfer decoder and its
// register block. Assumes a 32-bit AHB-Lite slave port with word registers.
`ifndef HSDT_REGS_VH
`define HSDT_REGS_VH
`define HSDT_CTRL_ADDR      8'h00
`define HSDT_STATUS_ADDR    8'h04
`define HSDT_COUNT_ADDR     8'h08
`define HSDT_LASTADDR_ADDR  8'h0c
`define HSDT_CTRL_RESET     32'h00000001
`define HSDT_CTRL_EN_BIT    0
`define HSDT_ST_BUSY_BIT    0
`define HSDT_ST_SKIP_BIT    1
`define HSDT_ST_SWAP_BIT    2
`define HSDT_BIT_IMM        22
`define HSDT_BIT_P          24
`define HSDT_BIT_U          23
`define HSDT_BIT_W          21
`define HSDT_BIT_L          20
`define HSDT_BIT_S          6
`define HSDT_BIT_H          5
`define HSDT_HTRANS_NONSEQ  2'h2
`endif

// ==== hsdt_load_align.v ====
// Picks the addressed byte or halfword off the read bus and extends it.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module hsdt_load_align
(
   input  wire [31:0] rdata,
   input  wire [1:0]  addr_lo,
   input  wire        big_endian,
   input  wire        signed_op,
   input  wire        half_op,
   output reg  [31:0] result
);
   reg  [1:0]  lane;
   reg  [7:0]  byte_sel;
   reg  [15:0] half_sel;

   always @*
   begin
      lane     = big_endian ? (2'h3 - addr_lo) : addr_lo;
      byte_sel = rdata[lane * 8 +: 8];
      if (addr_lo[1] ^ big_endian)
         half_sel = rdata[31:16];
      else
         half_sel = rdata[15:0];
      if (half_op && signed_op)
         result = {{16{half_sel[15]}}, half_sel};
      else if (half_op)
         result = {16'h0000, half_sel};
      else
         result = {{24{byte_sel[7]}}, byte_sel};
   end
endmodule

// ==== hsdt_decode_properties.sv ====
// Port checker for hsdt_decode: memory side, write-back and decode routes.
// Assumes the memory ack is a one-cycle pulse while a request stands.
`timescale 1ns/1ps
module hsdt_decode_properties
(
   input wire        clk_sys,
   input wire        rst,
   input wire [31:0] instr,
   input wire        instr_valid,
   input wire        instr_ready_ff,
   input wire        mem_req_ff,
   input wire [31:0] mem_addr_ff,
   input wire        mem_write_ff,
   input wire        mem_half_ff,
   input wire [31:0] mem_wdata_ff,
   input wire        mem_ack,
   input wire        load_we_ff,
   input wire [3:0]  load_reg_ff,
   input wire        base_we_ff,
   input wire [3:0]  base_reg_ff,
   input wire        done_ff,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic en_ff;
   logic ctrl_wr_ff;
   // Shadow of the enable bit, kept from the register bus alone.
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         en_ff      <= 1'b1;
         ctrl_wr_ff <= 1'b0;
      end
      else
      begin
         if (ctrl_wr_ff && hready)
            en_ff <= hwdata[0];
         if (hready)
            ctrl_wr_ff <= hsel && htrans == 2'h2 && hwrite &&
                          haddr[7:0] == 8'h00;
      end
   end
   wire take = en_ff && instr_valid && instr_ready_ff &&
               instr[27:25] == 3'h0 && instr[7] && instr[4];
   sequence s_ack; mem_req_ff && mem_ack; endsequence
   sequence s_finish; !mem_req_ff ##1 done_ff; endsequence
   property p_ack_done; s_ack |=> s_finish; endproperty
   a_ack_done: assert property (p_ack_done)
      else $error("no finish after memory ack");
   property p_hold; mem_req_ff && !mem_ack |=>
      mem_req_ff && $stable(mem_addr_ff); endproperty
   a_hold: assert property (p_hold)
      else $error("request dropped or address moved before ack");
   property p_store; mem_req_ff && mem_write_ff |->
      mem_half_ff && mem_wdata_ff[31:16] == mem_wdata_ff[15:0]; endproperty
   a_store: assert property (p_store)
      else $error("store data not a repeated halfword");
   property p_nv; take && instr[31:28] == 4'hf |=> !mem_req_ff [*2]; endproperty
   a_nv: assert property (p_nv)
      else $error("never condition started a transfer");
   property p_swap; take && instr[6:5] == 2'h0 |=> !mem_req_ff [*2]; endproperty
   a_swap: assert property (p_swap)
      else $error("swap encoding started a transfer");
   property p_exec; take && instr[31:28] == 4'he && instr[6:5] != 2'h0 &&
      (instr[22] || instr[11:8] == 4'h0) |=> mem_req_ff && !instr_ready_ff;
   endproperty
   a_exec: assert property (p_exec)
      else $error("always condition did not start a transfer");
   property p_wb; load_we_ff || base_we_ff |-> done_ff && $past(mem_ack, 2); endproperty
   a_wb: assert property (p_wb)
      else $error("register write not two cycles after ack");
   property p_wins; load_we_ff && base_we_ff |-> load_reg_ff != base_reg_ff; endproperty
   a_wins: assert property (p_wins)
      else $error("base and load write the same register");
endmodule
bind hsdt_decode hsdt_decode_properties u_hsdt_decode_properties (.*);

// ==== hsdt_mem_model.sv ====
// Memory on the decoder's data side: sixteen words and a settable wait.
// Assumes one request at a time, held until the ack pulse is seen.
`timescale 1ns/1ps
module hsdt_mem_model
(
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         endian_select_input,
   input  wire [3:0]   wait_cycles,
   input  wire         mem_req_ff,
   input  wire [31:0]  mem_addr_ff,
   input  wire         mem_write_ff,
   input  wire         mem_half_ff,
   input  wire [31:0]  mem_wdata_ff,
   output logic        mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [0:15];
   logic [3:0]  cnt_ff;
   wire  [3:0]  idx   = mem_addr_ff[5:2];
   wire         upper = mem_addr_ff[1] ^ endian_select_input;
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cnt_ff <= 4'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
      end
      else
      begin
         mem_ack <= 1'b0;
         // Outside an answer the bus toggles, so stale data never match.
         mem_rdata <= ~mem_rdata;
         if (mem_req_ff && !mem_ack && cnt_ff != wait_cycles)
            cnt_ff <= cnt_ff + 4'h1;
         else if (mem_req_ff && !mem_ack)
         begin
            cnt_ff <= 4'h0;
            mem_ack <= 1'b1;
            mem_rdata <= mem[idx];
            if (mem_write_ff && upper)
               mem[idx][31:16] <= mem_wdata_ff[31:16];
            else if (mem_write_ff)
               mem[idx][15:0] <= mem_wdata_ff[15:0];
         end
      end
   end
endmodule

// ==== halfword_signed_transfer_decode_bench.sv ====
// Self-checking bench for the halfword and signed transfer decoder.
// Assumes the memory model on the data port and one AHB-Lite master.
`timescale 1ns/1ps
module halfword_signed_transfer_decode_bench;
   logic        clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0;
   logic        endian_select_input = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] instr = 32'h0, base_value = 32'h0, index_value = 32'h0;
   logic [31:0] store_value = 32'h0, haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [3:0]  flags_nzcv = 4'h0, wait_cycles = 4'h0;
   logic        instr_ready_ff, mem_req_ff, mem_write_ff, mem_half_ff;
   logic        mem_ack, load_we_ff, base_we_ff, done_ff, swap_route_ff;
   logic        not_decoded_ff, hreadyout_ff, got_ld, got_b, sg, hf;
   logic [31:0] mem_addr_ff, mem_wdata_ff, mem_rdata, load_data_ff;
   logic [31:0] base_data_ff, hrdata_ff, ld, bd, ma, wd, rd;
   logic [3:0]  load_reg_ff, base_reg_ff, lr, br;
   logic [2:0]  ev;
   logic [1:0]  wh;
   logic        hresp_ff;
   logic [3:0]  cnd [3] = '{4'h0, 4'h0, 4'hf};
   integer      mismatches = 0, checks = 0, n;
   always #50 clk_sys = ~clk_sys;
   hsdt_decode u_hsdt_decode (.*, .hready(hreadyout_ff));
   hsdt_mem_model u_hsdt_mem_model (.*);
   task summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task check(input string nm, input [31:0] exp, input [31:0] got);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tick;
      @(posedge clk_sys);
      n++;
      if (n > 40)
      begin
         mismatches++;
         summarize;
      end
   endtask
   task ahb(input logic wr, input [31:0] a, input [31:0] d);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
      n = 0;
      do tick; while (!hreadyout_ff);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do tick; while (!hreadyout_ff);
      rd = hrdata_ff;
      check("hresp okay", 32'h0, hresp_ff);
   endtask
   task run(input [31:0] ins, input [31:0] b, input [31:0] x, input [31:0] s);
      instr <= ins; base_value <= b; index_value <= x; store_value <= s;
      instr_valid <= 1'b1;
      n = 0;
      do tick; while (!instr_ready_ff);
      instr_valid <= 1'b0;
      {got_ld, got_b, ev, ma, wh} = 39'h0;
      while (ev == 3'h0)
      begin
         tick;
         if (mem_req_ff) {ma, wd} = {mem_addr_ff, mem_wdata_ff};
         if (mem_req_ff) wh = {mem_write_ff, mem_half_ff};
         if (load_we_ff) {got_ld, lr, ld} = {1'b1, load_reg_ff, load_data_ff};
         if (base_we_ff) {got_b, br, bd} = {1'b1, base_reg_ff, base_data_ff};
         ev = {done_ff, swap_route_ff, not_decoded_ff};
      end
   endtask
   function [31:0] lane(input [31:0] w, input [1:0] a, input e, s, h);
      logic [7:0]  b;
      logic [15:0] hw;
      b = w >> (8 * (e ? 3 - a : a));
      hw = w >> (16 * (a[1] ^ e));
      lane = h ? {{16{s & hw[15]}}, hw} : {{24{b[7]}}, b};
   endfunction
   // Post-indexing keeps W clear and stores are never signed.
   function [31:0] enc(input [3:0] c, input [4:0] puiwl, input [3:0] rn, rt,
                       input [7:0] off, input [1:0] sh);
      enc = {c, 3'h0, puiwl, rn, rt, off[7:4], 1'b1, sh, 1'b1, off[3:0]};
   endfunction
   initial
   begin
      u_hsdt_mem_model.mem[0] = 32'h80f17f82;
      u_hsdt_mem_model.mem[2] = 32'h5a5a5a5a;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      ahb(1'b0, 32'h0, 32'h0);
      check("ctrl reset", 32'h1, rd);
      for (int k = 0; k < 24; k++)
      begin
         sg = (k / 4) % 3 != 2;
         hf = (k / 4) % 3 != 0;
         if (hf && k[0]) continue;
         endian_select_input <= k >= 12;
         run(enc(4'he, 5'b11101, 4'h2, 4'h1, {6'h0, k[1:0]}, {sg, hf}),
             32'h100, 32'h0, 32'h0);
         check("lane addr", 32'h100 + k % 4, ma);
         check("lane data", lane(32'h80f17f82, k[1:0], k >= 12, sg, hf), ld);
         check("lane writes", 32'h11, {got_b, got_ld, lr});
         check("lane kind", {1'b0, hf}, wh);
      end
      $display("lanes done");
      endian_select_input <= 1'b0;
      run(enc(4'he, 5'b10011, 4'h2, 4'h3, 8'h05, 2'h1), 32'h10c, 32'hc, 32'h0);
      check("reg addr", 32'h100, ma);
      check("uh data", 32'h7f82, ld);
      check("pre wb reg", 32'h12, {got_b, br});
      check("pre wb", 32'h100, bd);
      wait_cycles <= 4'h3;
      run(enc(4'he, 5'b01100, 4'h4, 4'h6, 8'h24, 2'h1), 32'h108, 32'h0, 32'hdead1234);
      check("post addr", 32'h108, ma);
      check("store data", 32'h12341234, wd);
      check("store kind", 32'h3, wh);
      check("post wb reg", 32'h14, {got_b, br});
      check("post wb", 32'h12c, bd);
      wait_cycles <= 4'h0;
      run(enc(4'he, 5'b11101, 4'h4, 4'h7, 8'h00, 2'h1), 32'h108, 32'h0, 32'h0);
      check("store readback", 32'h1234, ld);
      $display("index modes done");
      foreach (cnd[i])
      begin
         flags_nzcv <= (i == 0) ? 4'h0 : 4'h4;
         run(enc(cnd[i], 5'b11101, 4'h2, 4'h1, 8'h0, 2'h2), 32'h100, 32'h0, 32'h0);
         check("condition", {3'h4, i == 1}, {ev, got_ld});
      end
      ahb(1'b0, 32'h4, 32'h0);
      check("status fail", 32'h2, rd & 32'h2);
      run(enc(4'he, 5'b11101, 4'h2, 4'h1, 8'h0, 2'h0), 32'h100, 32'h0, 32'h0);
      check("swap route", 32'h4, {ev, got_ld});
      run(enc(4'he, 5'b10001, 4'h2, 4'h1, 8'h35, 2'h1), 32'h100, 32'h0, 32'h0);
      check("not decoded", 32'h2, {ev, got_ld});
      run(enc(4'he, 5'b11111, 4'h2, 4'h2, 8'h04, 2'h1), 32'hfc, 32'h0, 32'h0);
      check("load wins", 32'h22, {got_ld, got_b, lr});
      $display("routes done");
      ahb(1'b1, 32'h0, 32'h0);
      instr <= enc(4'he, 5'b11101, 4'h2, 4'h1, 8'h0, 2'h2);
      instr_valid <= 1'b1;
      repeat (4)
      begin
         @(posedge clk_sys);
         check("disabled", 32'h1, {mem_req_ff, done_ff, instr_ready_ff});
      end
      instr_valid <= 1'b0;
      ahb(1'b1, 32'h0, 32'h1);
      ahb(1'b0, 32'h8, 32'h0);
      check("count", 32'd21, rd);
      ahb(1'b0, 32'hc, 32'h0);
      check("last addr", 32'h100, rd);
      ahb(1'b1, 32'h10, 32'hffffffff);
      ahb(1'b0, 32'h10, 32'h0);
      check("unmapped", 32'h0, rd);
      $display("registers done");
      summarize;
   end
endmodule
